// >>> core/ixr_defs.vh
// Purpose: shared constants of the instruction execution block
// Assumes: included by its bare name from every design file
// Notes: definitions only
`ifndef IXR_DEFS_VH
`define IXR_DEFS_VH

// ----------------------------------------------------------------
// operation codes on op_code
// ----------------------------------------------------------------
`define IXR_OPW 5
`define IXR_OP_ROT_RC_WORK 5'h00
`define IXR_OP_MINB_WORK 5'h01
`define IXR_OP_MINB_MEM 5'h02
`define IXR_OP_MIN_WORK 5'h03
`define IXR_OP_MIN_MEM 5'h04
`define IXR_OP_MIN_IMM 5'h05
`define IXR_OP_DEC_SKIP 5'h06
`define IXR_OP_DEC_WORK_SKIP 5'h07
`define IXR_OP_INC_SKIP 5'h08
`define IXR_OP_INC_WORK_SKIP 5'h09
`define IXR_OP_SET_BYTE 5'h0A
`define IXR_OP_SET_BIT 5'h0B
`define IXR_OP_SKIP_BIT_NZ 5'h0C
`define IXR_OP_SKIP_ZERO 5'h0D
`define IXR_OP_COPY_SKIP_ZERO 5'h0E
`define IXR_OP_SKIP_BIT_Z 5'h0F
`define IXR_OP_NIB_MEM 5'h10
`define IXR_OP_NIB_WORK 5'h11
`define IXR_OP_TBL_CUR 5'h12
`define IXR_OP_TBL_FINAL 5'h13
`define IXR_OP_XOR_WORK 5'h14
`define IXR_OP_XOR_MEM 5'h15
`define IXR_OP_XOR_IMM 5'h16

// ----------------------------------------------------------------
// data widths and reset values
// ----------------------------------------------------------------
`define IXR_DW 8
`define IXR_PROG_DW 14
`define IXR_TABLE_HIGH_LATCH_W 6
`define IXR_ALL_ONES 8'hFF
`define IXR_WORK_RST 8'h00
`define IXR_TABLE_HIGH_LATCH_RST 6'h00
`define IXR_FLAGS_RST 4'h0
// flag vector layout: {signed_wrap, zero, half_carry, carry}
`define IXR_FLAG_C 0
`define IXR_FLAG_H 1
`define IXR_FLAG_Z 2
`define IXR_FLAG_V 3

`endif

// >>> core/ixr_alu.v
// Purpose: eight-bit adder with carry, half-carry, overflow and zero
// Assumes: subtraction is fed as a + ~b + cin by the caller
// Notes: purely combinational
`timescale 1ns/1ps
`include "ixr_defs.vh"

module ixr_alu (
	a,
	b,
	cin,
	sum,
	c_out,
	h_out,
	v_out,
	z_out
);
	input wire [7:0] a;
	input wire [7:0] b;
	input wire cin;
	output wire [7:0] sum;
	output wire c_out;
	output wire h_out;
	output wire v_out;
	output wire z_out;

	wire [4:0] low;
	wire [8:0] full;

	// ----------------------------------------------------------------
	// add and flags
	// ----------------------------------------------------------------
	assign low = {1'b0, a[3:0]} + {1'b0, b[3:0]} + {4'h0, cin};
	assign full = {1'b0, a} + {1'b0, b} + {8'h00, cin};
	assign sum = full[7:0];
	assign c_out = full[8];
	assign h_out = low[4];
	assign v_out = (a[7] == b[7]) && (sum[7] != a[7]);
	assign z_out = (sum == 8'h00);
endmodule

// >>> core/ixr_dmem.v
// Purpose: data memory with one write port and a registered read port
// Assumes: read data shows the word addressed at the previous edge
// Notes: a read and write of one word at one edge returns the old word
`timescale 1ns/1ps
`include "ixr_defs.vh"

module ixr_dmem #(
	parameter AW = 6
) (
	clk,
	wr_en,
	wr_addr,
	wr_data,
	rd_addr,
	rd_data
);
	input wire clk;
	input wire wr_en;
	input wire [AW-1:0] wr_addr;
	input wire [7:0] wr_data;
	input wire [AW-1:0] rd_addr;
	output reg [7:0] rd_data;

	reg [7:0] mem [0:(1<<AW)-1];

	always @(posedge clk) begin
		if (wr_en) begin
			mem[wr_addr] <= wr_data;
		end
		rd_data <= mem[rd_addr];
	end
endmodule

// >>> core/ixr_exec.v
// Purpose: executes rotate, subtract, skip, set, swap, table read and xor
// Assumes: op inputs, loads and program data come from logic on clk
// Notes: program memory answers while prog_rd_en stands; the word is taken at the edge ending it
// Functional notes
// - rotate right through carry into work register; only carry changes.
// - borrow subtract is work plus inverted operand plus carry, to work or memory.
// - plain subtract is work plus inverted operand plus one, flags updated.
// - true skip discards the prefetched instruction and adds one dummy cycle.
// - decrement memory, write back, skip when result zero.
// - decrement into work register, memory kept, skip when zero.
// - increment memory, write back, skip when result wraps to zero.
// - increment into work register, memory kept, skip when zero.
// - set byte writes all ones, flags unchanged.
// - set bit forces the chosen bit to one, others kept.
// - skip when the chosen bit is one; memory kept.
// - skip when the whole operand is zero; nothing modified.
// - copy operand into work register, skip when it is zero.
// - skip when the chosen bit is zero; memory kept.
// - swap operand nibbles in place, flags unchanged.
// - swapped operand into work register, memory kept, flags unchanged.
// - current page table read: low byte to memory, high to latch.
// - final page table read: low byte to memory, high to latch.
// - xor of work register and operand into work register.
// - xor into memory and zero flag updated.
// - xor with immediate into work register, zero flag updated.
`timescale 1ns/1ps
`include "ixr_defs.vh"

module ixr_exec #(
	parameter DATA_AW = 6,
	parameter PROG_AW = 10
) (
	clk,
	reset_n,
	op_valid,
	op_code,
	op_addr,
	op_bit,
	op_imm,
	table_pointer,
	pc_page,
	prog_data,
	load_en,
	load_work,
	load_flags,
	preload_en,
	preload_addr,
	preload_data,
	op_ready,
	done,
	skip,
	dummy_cycle,
	work_register,
	carry_flag,
	half_carry_flag,
	zero_flag,
	signed_wrap_flag,
	table_high_latch,
	prog_rd_en,
	prog_addr,
	mem_wr_valid,
	mem_wr_addr,
	mem_wr_data
);
	input wire clk;
	input wire reset_n;
	input wire op_valid;
	input wire [`IXR_OPW-1:0] op_code;
	input wire [DATA_AW-1:0] op_addr;
	input wire [2:0] op_bit;
	input wire [7:0] op_imm;
	input wire [7:0] table_pointer;
	input wire [PROG_AW-9:0] pc_page;
	input wire [`IXR_PROG_DW-1:0] prog_data;
	input wire load_en;
	input wire [7:0] load_work;
	input wire [3:0] load_flags;
	input wire preload_en;
	input wire [DATA_AW-1:0] preload_addr;
	input wire [7:0] preload_data;
	output wire op_ready;
	output wire done;
	output wire skip;
	output wire dummy_cycle;
	output wire [7:0] work_register;
	output wire carry_flag;
	output wire half_carry_flag;
	output wire zero_flag;
	output wire signed_wrap_flag;
	output wire [`IXR_TABLE_HIGH_LATCH_W-1:0] table_high_latch;
	output wire prog_rd_en;
	output wire [PROG_AW-1:0] prog_addr;
	output wire mem_wr_valid;
	output wire [DATA_AW-1:0] mem_wr_addr;
	output wire [7:0] mem_wr_data;

	localparam [1:0] ST_IDLE = 2'b00;
	localparam [1:0] ST_EXEC = 2'b01;
	localparam [1:0] ST_TABLE = 2'b10;
	localparam [1:0] ST_DUMMY = 2'b11;

	// ----------------------------------------------------------------
	// helpers
	// ----------------------------------------------------------------
	function [7:0] bit_mask;
		input [2:0] sel;
		begin
			bit_mask = 8'h01 << sel;
		end
	endfunction

	// ----------------------------------------------------------------
	// reset release
	// ----------------------------------------------------------------
	reg rst_meta_ff;
	reg rst_sync_ff;
	wire rst_n;

	always @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			rst_meta_ff <= 1'b0;
			rst_sync_ff <= 1'b0;
		end else begin
			rst_meta_ff <= 1'b1;
			rst_sync_ff <= rst_meta_ff;
		end
	end
	assign rst_n = rst_sync_ff;

	// ----------------------------------------------------------------
	// state
	// ----------------------------------------------------------------
	reg [1:0] state_ff;
	reg [`IXR_OPW-1:0] code_ff;
	reg [DATA_AW-1:0] addr_ff;
	reg [2:0] bit_ff;
	reg [7:0] imm_ff;
	reg [7:0] work_ff;
	reg [3:0] flags_ff;
	reg [`IXR_TABLE_HIGH_LATCH_W-1:0] table_high_latch_ff;
	reg ready_ff;
	reg done_ff;
	reg skip_ff;
	reg dummy_ff;
	reg prog_rd_ff;
	reg [PROG_AW-1:0] prog_addr_ff;
	reg wr_valid_ff;
	reg [DATA_AW-1:0] wr_addr_ff;
	reg [7:0] wr_data_ff;

	reg [1:0] nxt_state;
	reg [7:0] nxt_work;
	reg [3:0] nxt_flags;
	reg [`IXR_TABLE_HIGH_LATCH_W-1:0] nxt_table_high_latch;
	reg nxt_done;
	reg nxt_skip;
	reg nxt_prog_rd;
	reg [PROG_AW-1:0] nxt_prog_addr;
	reg nxt_wr;
	reg [7:0] nxt_wr_data;

	wire accept;
	wire [7:0] mem_q;
	wire [7:0] alu_b;
	wire alu_cin;
	wire [7:0] alu_sum;
	wire alu_c;
	wire alu_h;
	wire alu_v;
	wire alu_z;
	wire [7:0] dec_val;
	wire [7:0] inc_val;
	wire [7:0] xor_m;
	wire [7:0] xor_i;
	wire [7:0] nib_val;
	wire bit_set;
	wire dm_wr_en;
	wire [DATA_AW-1:0] dm_wr_addr;
	wire [7:0] dm_wr_data;

	assign accept = op_valid && ready_ff;

	// ----------------------------------------------------------------
	// datapath
	// ----------------------------------------------------------------
	// immediate subtract inverts the immediate, all others the memory operand
	assign alu_b = (code_ff == `IXR_OP_MIN_IMM) ? ~imm_ff : ~mem_q;
	assign alu_cin = ((code_ff == `IXR_OP_MINB_WORK) || (code_ff == `IXR_OP_MINB_MEM)) ?
		flags_ff[`IXR_FLAG_C] : 1'b1;

	ixr_alu u_alu (
		.a(work_ff),
		.b(alu_b),
		.cin(alu_cin),
		.sum(alu_sum),
		.c_out(alu_c),
		.h_out(alu_h),
		.v_out(alu_v),
		.z_out(alu_z)
	);

	assign dec_val = mem_q - 8'h01;
	assign inc_val = mem_q + 8'h01;
	assign xor_m = work_ff ^ mem_q;
	assign xor_i = work_ff ^ imm_ff;
	assign nib_val = {mem_q[3:0], mem_q[7:4]};
	assign bit_set = |(mem_q & bit_mask(bit_ff));

	// ----------------------------------------------------------------
	// execute decode
	// ----------------------------------------------------------------
	always @* begin
		nxt_state = state_ff;
		nxt_work = work_ff;
		nxt_flags = flags_ff;
		nxt_table_high_latch = table_high_latch_ff;
		nxt_done = 1'b0;
		nxt_skip = 1'b0;
		nxt_prog_rd = 1'b0;
		nxt_prog_addr = prog_addr_ff;
		nxt_wr = 1'b0;
		nxt_wr_data = mem_q;
		case (state_ff)
		ST_IDLE: begin
			if (accept) begin
				nxt_state = ST_EXEC;
			end else if (load_en) begin
				nxt_work = load_work;
				nxt_flags = load_flags;
			end
		end
		ST_EXEC: begin
			nxt_done = 1'b1;
			case (code_ff)
			`IXR_OP_ROT_RC_WORK: begin
				nxt_work = {flags_ff[`IXR_FLAG_C], mem_q[7:1]};
				nxt_flags[`IXR_FLAG_C] = mem_q[0];
			end
			`IXR_OP_MINB_WORK, `IXR_OP_MIN_WORK, `IXR_OP_MIN_IMM: begin
				nxt_work = alu_sum;
				nxt_flags = {alu_v, alu_z, alu_h, alu_c};
			end
			`IXR_OP_MINB_MEM, `IXR_OP_MIN_MEM: begin
				nxt_wr = 1'b1;
				nxt_wr_data = alu_sum;
				nxt_flags = {alu_v, alu_z, alu_h, alu_c};
			end
			`IXR_OP_DEC_SKIP: begin
				nxt_wr = 1'b1;
				nxt_wr_data = dec_val;
				nxt_skip = (dec_val == 8'h00);
			end
			`IXR_OP_DEC_WORK_SKIP: begin
				nxt_work = dec_val;
				nxt_skip = (dec_val == 8'h00);
			end
			`IXR_OP_INC_SKIP: begin
				nxt_wr = 1'b1;
				nxt_wr_data = inc_val;
				nxt_skip = (inc_val == 8'h00);
			end
			`IXR_OP_INC_WORK_SKIP: begin
				nxt_work = inc_val;
				nxt_skip = (inc_val == 8'h00);
			end
			`IXR_OP_SET_BYTE: begin
				nxt_wr = 1'b1;
				nxt_wr_data = `IXR_ALL_ONES;
			end
			`IXR_OP_SET_BIT: begin
				nxt_wr = 1'b1;
				nxt_wr_data = mem_q | bit_mask(bit_ff);
			end
			`IXR_OP_SKIP_BIT_NZ: begin
				nxt_skip = bit_set;
			end
			`IXR_OP_SKIP_ZERO: begin
				nxt_skip = (mem_q == 8'h00);
			end
			`IXR_OP_COPY_SKIP_ZERO: begin
				nxt_work = mem_q;
				nxt_skip = (mem_q == 8'h00);
			end
			`IXR_OP_SKIP_BIT_Z: begin
				nxt_skip = !bit_set;
			end
			`IXR_OP_NIB_MEM: begin
				nxt_wr = 1'b1;
				nxt_wr_data = nib_val;
			end
			`IXR_OP_NIB_WORK: begin
				nxt_work = nib_val;
			end
			`IXR_OP_TBL_CUR: begin
				nxt_done = 1'b0;
				nxt_prog_rd = 1'b1;
				nxt_prog_addr = {pc_page, table_pointer};
				nxt_state = ST_TABLE;
			end
			`IXR_OP_TBL_FINAL: begin
				nxt_done = 1'b0;
				nxt_prog_rd = 1'b1;
				nxt_prog_addr = {{(PROG_AW-8){1'b1}}, table_pointer};
				nxt_state = ST_TABLE;
			end
			`IXR_OP_XOR_WORK: begin
				nxt_work = xor_m;
				nxt_flags[`IXR_FLAG_Z] = (xor_m == 8'h00);
			end
			`IXR_OP_XOR_MEM: begin
				nxt_wr = 1'b1;
				nxt_wr_data = xor_m;
				nxt_flags[`IXR_FLAG_Z] = (xor_m == 8'h00);
			end
			`IXR_OP_XOR_IMM: begin
				nxt_work = xor_i;
				nxt_flags[`IXR_FLAG_Z] = (xor_i == 8'h00);
			end
			default: begin
				nxt_done = 1'b1;
			end
			endcase
			if (nxt_state == ST_EXEC) begin
				// a true skip costs one extra cycle for the discarded fetch
				nxt_state = nxt_skip ? ST_DUMMY : ST_IDLE;
			end
		end
		ST_TABLE: begin
			nxt_done = 1'b1;
			nxt_wr = 1'b1;
			nxt_wr_data = prog_data[7:0];
			nxt_table_high_latch = prog_data[`IXR_PROG_DW-1:8];
			nxt_state = ST_IDLE;
		end
		ST_DUMMY: begin
			nxt_state = ST_IDLE;
		end
		default: begin
			nxt_state = ST_IDLE;
		end
		endcase
	end

	// ----------------------------------------------------------------
	// data memory
	// ----------------------------------------------------------------
	// preload is only taken while idle so it never collides with write-back
	assign dm_wr_en = nxt_wr || (preload_en && (state_ff == ST_IDLE));
	assign dm_wr_addr = nxt_wr ? addr_ff : preload_addr;
	assign dm_wr_data = nxt_wr ? nxt_wr_data : preload_data;

	ixr_dmem #(
		.AW(DATA_AW)
	) u_dmem (
		.clk(clk),
		.wr_en(dm_wr_en),
		.wr_addr(dm_wr_addr),
		.wr_data(dm_wr_data),
		.rd_addr(op_addr),
		.rd_data(mem_q)
	);

	// ----------------------------------------------------------------
	// registers
	// ----------------------------------------------------------------
	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			state_ff <= ST_IDLE;
			code_ff <= `IXR_OP_ROT_RC_WORK;
			addr_ff <= {DATA_AW{1'b0}};
			bit_ff <= 3'h0;
			imm_ff <= 8'h00;
			work_ff <= `IXR_WORK_RST;
			flags_ff <= `IXR_FLAGS_RST;
			table_high_latch_ff <= `IXR_TABLE_HIGH_LATCH_RST;
			ready_ff <= 1'b0;
			done_ff <= 1'b0;
			skip_ff <= 1'b0;
			dummy_ff <= 1'b0;
			prog_rd_ff <= 1'b0;
			prog_addr_ff <= {PROG_AW{1'b0}};
			wr_valid_ff <= 1'b0;
			wr_addr_ff <= {DATA_AW{1'b0}};
			wr_data_ff <= 8'h00;
		end else begin
			state_ff <= nxt_state;
			if (accept) begin
				code_ff <= op_code;
				addr_ff <= op_addr;
				bit_ff <= op_bit;
				imm_ff <= op_imm;
			end
			work_ff <= nxt_work;
			flags_ff <= nxt_flags;
			table_high_latch_ff <= nxt_table_high_latch;
			ready_ff <= (nxt_state == ST_IDLE) && !accept;
			done_ff <= nxt_done;
			skip_ff <= nxt_skip;
			dummy_ff <= (nxt_state == ST_DUMMY);
			prog_rd_ff <= nxt_prog_rd;
			prog_addr_ff <= nxt_prog_addr;
			wr_valid_ff <= nxt_wr;
			wr_addr_ff <= addr_ff;
			wr_data_ff <= nxt_wr_data;
		end
	end

	// ----------------------------------------------------------------
	// outputs
	// ----------------------------------------------------------------
	assign op_ready = ready_ff;
	assign done = done_ff;
	assign skip = skip_ff;
	assign dummy_cycle = dummy_ff;
	assign work_register = work_ff;
	assign carry_flag = flags_ff[`IXR_FLAG_C];
	assign half_carry_flag = flags_ff[`IXR_FLAG_H];
	assign zero_flag = flags_ff[`IXR_FLAG_Z];
	assign signed_wrap_flag = flags_ff[`IXR_FLAG_V];
	assign table_high_latch = table_high_latch_ff;
	assign prog_rd_en = prog_rd_ff;
	assign prog_addr = prog_addr_ff;
	assign mem_wr_valid = wr_valid_ff;
	assign mem_wr_addr = wr_addr_ff;
	assign mem_wr_data = wr_data_ff;
endmodule

// >>> verification/ixr_prog_model.sv
// Purpose: program memory behind the table reads
// Assumes: word wanted at the edge that closes the cycle in which prog_rd_en stands
// Notes: word pattern depends on page and offset
`timescale 1ns/1ps
module ixr_prog_model #(
	parameter PROG_AW = 10
) (
	input wire clk,
	input wire prog_rd_en,
	input wire [PROG_AW-1:0] prog_addr,
	output wire [13:0] prog_data
);
	logic [13:0] idle_q;
	initial idle_q = 14'h1555;
	// toggles outside a read so a stale word never passes for a fresh one
	always @(posedge clk) begin
		idle_q <= ~idle_q;
	end
	// the core takes the word while its read request still stands
	assign prog_data = prog_rd_en ? {prog_addr[PROG_AW-1:PROG_AW-2], prog_addr[3:0], ~prog_addr[7:0]} : idle_q;
endmodule

// >>> verification/ixr_exec_props.sv
// Purpose: port timing and result checks of the execution block
// Assumes: codes from ixr_defs.vh
// Notes: bound from tb_top
`timescale 1ns/1ps
`include "ixr_defs.vh"
module ixr_exec_props (
	input wire clk,
	input wire reset_n,
	input wire op_valid,
	input wire op_ready,
	input wire [`IXR_OPW-1:0] op_code,
	input wire [7:0] op_imm,
	input wire done,
	input wire skip,
	input wire dummy_cycle,
	input wire prog_rd_en,
	input wire mem_wr_valid,
	input wire [7:0] work_register,
	input wire carry_flag,
	input wire half_carry_flag,
	input wire zero_flag,
	input wire signed_wrap_flag
);
	wire acc = op_valid && op_ready;
	wire tbl = op_code == `IXR_OP_TBL_CUR || op_code == `IXR_OP_TBL_FINAL;
	wire [3:0] flg = {signed_wrap_flag, zero_flag, half_carry_flag, carry_flag};
	wire [2:0] hi_flg = flg[3:1];
	default clocking @(posedge clk); endclocking
	default disable iff (!reset_n);
	AST_SKIP_DUMMY: assert property (
		skip |-> done && dummy_cycle) else $error("skip without done and dummy cycle");
	AST_SKIP_GAP: assert property (
		skip |-> !op_ready ##1 op_ready) else $error("skip did not take one extra cycle");
	AST_NOSKIP_READY: assert property (
		done && !skip |-> op_ready) else $error("plain completion not ready at once");
	AST_PLAIN_LAT: assert property (
		acc && !tbl |-> ##2 done) else $error("done late");
	AST_TBL_SEQ: assert property (
		acc && tbl |-> ##2 prog_rd_en ##1 (done && mem_wr_valid)) else $error("table read sequence wrong");
	AST_ROT_FLAGS: assert property (
		acc && op_code == `IXR_OP_ROT_RC_WORK |-> ##2 hi_flg == $past(hi_flg, 2)) else $error("rotate moved flags");
	AST_KEEP_FLAGS: assert property (
		acc && op_code >= `IXR_OP_DEC_SKIP && op_code <= `IXR_OP_TBL_FINAL |-> ##2 flg == $past(flg, 2))
		else $error("flags changed");
	AST_XOR_IMM: assert property (
		acc && op_code == `IXR_OP_XOR_IMM |-> ##2 work_register == ($past(work_register, 2) ^ $past(op_imm, 2))
		&& zero_flag == (work_register == 8'h00)) else $error("xor immediate wrong");
	AST_MIN_IMM: assert property (
		acc && op_code == `IXR_OP_MIN_IMM |-> ##2 {carry_flag, work_register} ==
		({1'b0, $past(work_register, 2)} + {1'b0, ~$past(op_imm, 2)} + 9'h001)) else $error("minus immediate wrong");
endmodule

// >>> verification/tb_top.sv
// Purpose: random instruction stream checked against a reference model
// Assumes: 125 MHz clock, data memory preloaded before use
// Notes: memory holds 00, 01 and FF often so skips and wraps occur
`timescale 1ns/1ps
`include "ixr_defs.vh"
module tb_top;
	logic clk, reset_n, op_valid, load_en, preload_en, sk, wr, ci;
	logic [4:0] op_code, c;
	logic [5:0] op_addr, preload_addr, a, th;
	logic [2:0] op_bit, bt;
	logic [7:0] op_imm, table_pointer, load_work, preload_data, w, m, r, b;
	logic [1:0] pc_page;
	logic [3:0] load_flags, fl;
	logic [8:0] s;
	logic [13:0] pw;
	logic [31:0] rnd = 32'h84946CC8;
	logic [7:0] mem [64];
	wire [13:0] prog_data;
	wire op_ready, done, skip, dummy_cycle, carry_flag, half_carry_flag, zero_flag, signed_wrap_flag;
	wire prog_rd_en, mem_wr_valid;
	wire [7:0] work_register, mem_wr_data;
	wire [5:0] table_high_latch, mem_wr_addr;
	wire [9:0] prog_addr;
	int miscompares = 0, compares = 0, i, n;
	ixr_exec u_dut (.clk(clk), .reset_n(reset_n), .op_valid(op_valid), .op_code(op_code), .op_addr(op_addr),
		.op_bit(op_bit), .op_imm(op_imm), .table_pointer(table_pointer), .pc_page(pc_page), .prog_data(prog_data),
		.load_en(load_en), .load_work(load_work), .load_flags(load_flags), .preload_en(preload_en),
		.preload_addr(preload_addr), .preload_data(preload_data), .op_ready(op_ready), .done(done), .skip(skip),
		.dummy_cycle(dummy_cycle), .work_register(work_register), .carry_flag(carry_flag),
		.half_carry_flag(half_carry_flag), .zero_flag(zero_flag), .signed_wrap_flag(signed_wrap_flag),
		.table_high_latch(table_high_latch), .prog_rd_en(prog_rd_en), .prog_addr(prog_addr),
		.mem_wr_valid(mem_wr_valid), .mem_wr_addr(mem_wr_addr), .mem_wr_data(mem_wr_data));
	ixr_prog_model u_pm (.clk(clk), .prog_rd_en(prog_rd_en), .prog_addr(prog_addr), .prog_data(prog_data));
	initial begin
		clk = 0;
		forever #4 clk = ~clk;
	end
	// ----------------------------------------------------------------
	// helpers
	// ----------------------------------------------------------------
	function automatic logic [31:0] lfsr_next(input logic [31:0] v);
		for (int k = 0; k < 32; k++) v = {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
		return v;
	endfunction
	task automatic step;
		rnd = lfsr_next(rnd);
	endtask
	task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
		compares++;
		if (e !== g) begin
			miscompares++;
			$display("wrong value %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic stop_test;
		$display("compares %0d miscompares %0d", compares, miscompares);
		if (miscompares == 0 && compares > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask
	// checked at the falling edge, where flop outputs are settled
	task automatic await(input bit on_done);
		n = 0;
		while ((on_done ? done : op_ready) !== 1'b1 && n < 50) begin
			@(negedge clk);
			n++;
		end
		if (n >= 50) begin
			miscompares++;
			stop_test;
		end
	endtask
	// ----------------------------------------------------------------
	// one instruction: optional load, offer, reference, compare
	// ----------------------------------------------------------------
	task automatic do_op;
		step;
		await(0);
		if (rnd[0]) begin
			@(posedge clk);
			load_en <= 1;
			load_work <= rnd[8:1];
			load_flags <= rnd[12:9];
			w = rnd[8:1];
			fl = rnd[12:9];
		end
		step;
		c = 5'(rnd[4:0] % 23);
		a = rnd[10:5];
		bt = rnd[13:11];
		@(posedge clk);
		load_en <= 0;
		op_valid <= 1;
		op_code <= c;
		op_addr <= a;
		op_bit <= bt;
		op_imm <= rnd[21:14];
		table_pointer <= rnd[29:22];
		pc_page <= rnd[31:30];
		@(negedge clk);
		await(0);
		@(posedge clk);
		op_valid <= 0;
		m = mem[a];
		sk = 0;
		wr = 0;
		r = m;
		case (c)
			`IXR_OP_ROT_RC_WORK: begin
				w = {fl[0], m[7:1]};
				fl[0] = m[0];
			end
			`IXR_OP_MINB_WORK, `IXR_OP_MINB_MEM, `IXR_OP_MIN_WORK, `IXR_OP_MIN_MEM, `IXR_OP_MIN_IMM: begin
				b = (c == `IXR_OP_MIN_IMM) ? rnd[21:14] : m;
				ci = (c <= `IXR_OP_MINB_MEM) ? fl[0] : 1'b1;
				s = w + {1'b0, ~b} + ci;
				fl[1] = ({1'b0, w[3:0]} + {1'b0, ~b[3:0]} + ci) > 5'h0F;
				fl[3] = (w[7] == ~b[7]) && (s[7] != w[7]);
				fl[0] = s[8];
				fl[2] = s[7:0] == 8'h00;
				r = s[7:0];
				wr = c == `IXR_OP_MINB_MEM || c == `IXR_OP_MIN_MEM;
				if (!wr) w = r;
			end
			`IXR_OP_DEC_SKIP, `IXR_OP_DEC_WORK_SKIP, `IXR_OP_INC_SKIP, `IXR_OP_INC_WORK_SKIP: begin
				r = (c < `IXR_OP_INC_SKIP) ? m - 8'h01 : m + 8'h01;
				sk = r == 8'h00;
				wr = c == `IXR_OP_DEC_SKIP || c == `IXR_OP_INC_SKIP;
				if (!wr) w = r;
			end
			`IXR_OP_SET_BYTE: {wr, r} = {1'b1, `IXR_ALL_ONES};
			`IXR_OP_SET_BIT: {wr, r} = {1'b1, m | (8'h01 << bt)};
			`IXR_OP_SKIP_BIT_NZ: sk = m[bt];
			`IXR_OP_SKIP_ZERO: sk = m == 8'h00;
			`IXR_OP_COPY_SKIP_ZERO: {sk, w} = {m == 8'h00, m};
			`IXR_OP_SKIP_BIT_Z: sk = !m[bt];
			`IXR_OP_NIB_MEM: {wr, r} = {1'b1, m[3:0], m[7:4]};
			`IXR_OP_NIB_WORK: w = {m[3:0], m[7:4]};
			`IXR_OP_TBL_CUR, `IXR_OP_TBL_FINAL: begin
				pw = (c == `IXR_OP_TBL_FINAL) ? 2'b11 : rnd[31:30];
				pw = {pw[1:0], rnd[25:22], ~rnd[29:22]};
				{wr, r, th} = {1'b1, pw[7:0], pw[13:8]};
			end
			`IXR_OP_XOR_WORK, `IXR_OP_XOR_IMM: begin
				w = w ^ ((c == `IXR_OP_XOR_IMM) ? rnd[21:14] : m);
				fl[2] = w == 8'h00;
			end
			`IXR_OP_XOR_MEM: {wr, r, fl[2]} = {1'b1, w ^ m, (w ^ m) == 8'h00};
			default: ;
		endcase
		if (wr) mem[a] = r;
		@(negedge clk);
		await(1);
		chk("work", w, work_register);
		chk("flags", fl, {signed_wrap_flag, zero_flag, half_carry_flag, carry_flag});
		chk("skip", {sk, sk}, {skip, dummy_cycle});
		chk("write", wr ? {1'b1, a, r} : 15'h0000,
			mem_wr_valid ? {1'b1, mem_wr_addr, mem_wr_data} : 15'h0000);
		chk("latch", th, table_high_latch);
	endtask
	// ----------------------------------------------------------------
	// main sequence
	// ----------------------------------------------------------------
	initial begin
		{reset_n, op_valid, load_en, preload_en, op_code, op_addr, op_bit, op_imm} = '0;
		{table_pointer, pc_page, load_work, load_flags, preload_addr, preload_data} = '0;
		{w, fl, th} = '0;
		repeat (20) @(posedge clk);
		reset_n <= 1;
		@(negedge clk);
		await(0);
		chk("reset", 16'h0000, {work_register, table_high_latch, flg_now()});
		for (i = 0; i < 64; i++) begin
			step;
			mem[i] = (i % 4 == 0) ? 8'h00 : (i % 4 == 1) ? 8'h01 : (i % 4 == 2) ? 8'hFF : rnd[7:0];
			@(posedge clk);
			preload_en <= 1;
			preload_addr <= i[5:0];
			preload_data <= mem[i];
		end
		@(posedge clk);
		preload_en <= 0;
		@(negedge clk);
		repeat (400) do_op;
		stop_test;
	end
	function automatic logic [1:0] flg_now;
		return {zero_flag | signed_wrap_flag, carry_flag | half_carry_flag};
	endfunction
endmodule
bind ixr_exec ixr_exec_props u_props (.clk(clk), .reset_n(reset_n), .op_valid(op_valid), .op_ready(op_ready),
	.op_code(op_code), .op_imm(op_imm), .done(done), .skip(skip), .dummy_cycle(dummy_cycle),
	.prog_rd_en(prog_rd_en), .mem_wr_valid(mem_wr_valid), .work_register(work_register),
	.carry_flag(carry_flag), .half_carry_flag(half_carry_flag), .zero_flag(zero_flag),
	.signed_wrap_flag(signed_wrap_flag));
